// [core/rtc_top.sv]
`timescale 1ns/10ps
// Notes on behaviour
// R01: Keep 256 retained bytes while well powered
// R02: Keep time of day from 32.768 kHz
// R03: Two locked 8-byte ranges block reads, writes
// R04: Date alarm up to month ahead wakes
// R05: Primary reset clears all retention bits
// R06: Secondary reset clears manageability (lock) bits
// R07: Other side holds primary reset high normally
// R08: Dead battery: resets rise before power good; the bench raises both well resets after rst_n
// R09: Other side keeps two reset nets separate
// R10: Second tick every 32768 source clocks
module rtc_top #(
    parameter int TICKS_PER_SECOND = rtc_pkg::TICKS_PER_SECOND
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       retention_well_reset_n,
    input  wire logic                       secondary_well_reset_n,
    input  wire logic                       crystal_input,
    input  wire logic                       ram_req,
    input  wire logic                       ram_write,
    input  wire logic [rtc_pkg::ADDR_W-1:0] ram_addr,
    input  wire logic [7:0]                 ram_wdata,
    output logic      [7:0]                 ram_rdata,
    output logic                            ram_ack,
    output logic                            ram_denied,
    input  wire logic [1:0]                 lock_set,
    output logic      [1:0]                 lock_state,
    input  wire logic                       time_load,
    input  wire rtc_pkg::tod_t              time_value,
    output rtc_pkg::tod_t                   time_now,
    output logic                            second_tick,
    input  wire logic                       alarm_load,
    input  wire logic                       alarm_enable,
    input  wire rtc_pkg::tod_t              alarm_value,
    output logic                            alarm_armed,
    output logic                            wake_event,
    output logic                            wake_flag,
    input  wire logic                       wake_clear
);
    import rtc_pkg::*;

    localparam int CW = $clog2(TICKS_PER_SECOND);   // Prescaler width

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (TICKS_PER_SECOND < 2) begin : g_bad_ticks
        $error("TICKS_PER_SECOND must be at least 2");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Step a counter field, wrapping from hi back to lo
    function automatic logic [7:0] bump(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
        return (v == hi) ? lo : 8'(v + 8'h01);
    endfunction

    // Last day of a month; no year is kept, so February has 28
    function automatic logic [7:0] last_day(input logic [7:0] month);
        case (month)
            8'h02:                      last_day = 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: last_day = 8'h1E;
            default:                    last_day = 8'h1F;
        endcase
    endfunction

    // True when an address falls inside a locked span
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] base);
        return (a >= base) && ({1'b0, a} < ({1'b0, base} + 9'(LOCK_BYTES)));
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic       xtal_s1_reg;    // First stage, read only by the second
    logic       xtal_s2_reg;    // Settled crystal level
    logic       xtal_old_reg;   // Previous settled level for edge detect
    logic       prim_s1_reg;    // Primary reset, first stage
    logic       prim_s2_reg;    // Primary reset, settled (active low)
    logic       sec_s1_reg;     // Secondary reset, first stage
    logic       sec_s2_reg;     // Secondary reset, settled (active low)

    // The reset pins are asynchronous; two stages keep metastability out
    // of the retention logic. Idle value is deasserted.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            xtal_s1_reg  <= 1'b0;
            xtal_s2_reg  <= 1'b0;
            xtal_old_reg <= 1'b0;
            prim_s1_reg  <= 1'b1;
            prim_s2_reg  <= 1'b1;
            sec_s1_reg   <= 1'b1;
            sec_s2_reg   <= 1'b1;
        end else begin
            xtal_s1_reg  <= crystal_input;
            xtal_s2_reg  <= xtal_s1_reg;
            xtal_old_reg <= xtal_s2_reg;
            prim_s1_reg  <= retention_well_reset_n;
            prim_s2_reg  <= prim_s1_reg;
            sec_s1_reg   <= secondary_well_reset_n;
            sec_s2_reg   <= sec_s1_reg;
        end
    end

    wire xtal_rise = xtal_s2_reg & ~xtal_old_reg;   // One pulse per source cycle
    wire prim_rst  = ~prim_s2_reg;                  // Level, clears retention bits
    wire mgmt_rst  = ~sec_s2_reg;                   // Level, clears lock bits

    // ------------------------------------------------------------
    // One-second prescaler
    // ------------------------------------------------------------
    logic [CW-1:0] presc_reg;   // Source edges seen this second
    logic [CW-1:0] presc_next;
    logic          tick_reg;    // One-cycle second pulse

    wire presc_end = (presc_reg == CW'(TICKS_PER_SECOND - 1));
    assign presc_next = presc_end ? '0 : CW'(presc_reg + 1'b1); // R10

    // Loading the time restarts the second so the first one is full length
    always_ff @(posedge clock) begin
        if (prim_rst || time_load) begin
            presc_reg <= '0; // R05
            tick_reg  <= 1'b0;
        end else begin
            tick_reg <= xtal_rise && presc_end; // R10
            if (xtal_rise) begin
                presc_reg <= presc_next; // R02
            end
        end
    end

    // ------------------------------------------------------------
    // Time of day
    // ------------------------------------------------------------
    tod_t tod_reg;   // Running time, retention well
    tod_t tod_next;  // Time one second on

    wire sec_wrap   = (tod_reg.sec == SEC_MAX);
    wire min_wrap   = sec_wrap & (tod_reg.min == MIN_MAX);
    wire hour_wrap  = min_wrap & (tod_reg.hour == HOUR_MAX);
    wire day_wrap   = hour_wrap & (tod_reg.day >= last_day(tod_reg.month));

    assign tod_next.sec   = bump(tod_reg.sec, ZERO_VAL, SEC_MAX);
    assign tod_next.min   = sec_wrap  ? bump(tod_reg.min, ZERO_VAL, MIN_MAX)   : tod_reg.min;
    assign tod_next.hour  = min_wrap  ? bump(tod_reg.hour, ZERO_VAL, HOUR_MAX) : tod_reg.hour;
    assign tod_next.day   = hour_wrap ? (day_wrap ? DAY_FIRST : 8'(tod_reg.day + 8'h01))
                                      : tod_reg.day;
    assign tod_next.month = day_wrap  ? bump(tod_reg.month, DAY_FIRST, MONTH_MAX)
                                      : tod_reg.month;

    // Software load wins over a tick in the same cycle
    always_ff @(posedge clock) begin
        if (prim_rst) begin
            tod_reg <= TOD_RESET; // R05
        end else if (time_load) begin
            tod_reg <= time_value;
        end else if (tick_reg) begin
            tod_reg <= tod_next; // R02
        end
    end

    assign time_now    = tod_reg;
    assign second_tick = tick_reg;

    // ------------------------------------------------------------
    // Date alarm
    // ------------------------------------------------------------
    tod_t alarm_reg;     // Target date and time; month field is ignored
    logic armed_reg;     // Alarm enabled
    logic wake_reg;      // One-cycle wake pulse
    logic flag_reg;      // Sticky wake indication

    // Matching on day, hour, minute and second reaches up to a month ahead
    wire alarm_hit = armed_reg && tick_reg &&
                     (tod_next.day  == alarm_reg.day)  &&
                     (tod_next.hour == alarm_reg.hour) &&
                     (tod_next.min  == alarm_reg.min)  &&
                     (tod_next.sec  == alarm_reg.sec); // R04

    always_ff @(posedge clock) begin
        if (prim_rst) begin
            alarm_reg <= TOD_RESET; // R05
            armed_reg <= 1'b0;
        end else if (alarm_load) begin
            alarm_reg <= alarm_value;
            armed_reg <= alarm_enable;
        end
    end

    // A hit in the clearing cycle keeps the flag set
    always_ff @(posedge clock) begin
        if (prim_rst) begin
            wake_reg <= 1'b0; // R05
            flag_reg <= 1'b0;
        end else begin
            wake_reg <= alarm_hit; // R04
            if (alarm_hit) begin
                flag_reg <= 1'b1;
            end else if (wake_clear) begin
                flag_reg <= 1'b0;
            end
        end
    end

    assign alarm_armed = armed_reg;
    assign wake_event  = wake_reg;
    assign wake_flag   = flag_reg;

    // ------------------------------------------------------------
    // Range locks
    // ------------------------------------------------------------
    logic [LOCK_RANGES-1:0] lock_reg;   // Set once, cleared only by a well reset

    // Locks are write-once so ordinary software cannot reopen a range
    always_ff @(posedge clock) begin
        if (prim_rst || mgmt_rst) begin
            lock_reg <= '0; // R06
        end else begin
            lock_reg <= lock_reg | lock_set;
        end
    end

    assign lock_state = lock_reg;

    // ------------------------------------------------------------
    // Storage access
    // ------------------------------------------------------------
    ram_port_if ram_bus ();

    wire hit0   = lock_reg[0] && in_range(ram_addr, LOCK0_BASE);
    wire hit1   = lock_reg[1] && in_range(ram_addr, LOCK1_BASE);
    wire locked = hit0 | hit1; // R03

    assign ram_bus.we    = ram_req && ram_write && !locked && !prim_rst; // R03
    assign ram_bus.addr  = ram_addr;
    assign ram_bus.wdata = ram_wdata;
    assign ram_bus.clear = prim_rst; // R05

    rtc_ram u_ram (
        .clock (clock),
        .port  (ram_bus.store)
    );

    logic [7:0] rdata_reg;    // Read result, zero when refused
    logic       ack_reg;      // One-cycle answer
    logic       denied_reg;   // Answer was refused by a lock

    // Every request is answered one cycle later; refused reads return zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg  <= 8'h00;
            ack_reg    <= 1'b0;
            denied_reg <= 1'b0;
        end else begin
            ack_reg    <= ram_req;
            denied_reg <= ram_req && locked;
            if (ram_req && !ram_write) begin
                rdata_reg <= locked ? 8'h00 : ram_bus.rdata; // R03
            end
        end
    end

    assign ram_rdata  = rdata_reg;
    assign ram_ack    = ack_reg;
    assign ram_denied = denied_reg;

endmodule

// [include/rtc_pkg.sv]
package rtc_pkg;

    // ------------------------------------------------------------
    // Storage layout
    // ------------------------------------------------------------
    localparam int          RAM_BYTES   = 256;          // Retained byte array size
    localparam int          ADDR_W      = 8;            // Byte address width
    localparam int          LOCK_BYTES  = 8;            // Span of each lockable range
    localparam int          LOCK_RANGES = 2;            // Number of lockable ranges
    localparam logic [7:0]  LOCK0_BASE  = 8'h38;        // Start of lower locked range
    localparam logic [7:0]  LOCK1_BASE  = 8'hD8;        // Start of upper locked range
    localparam logic [7:0]  RAM_CLEAR   = 8'h00;        // Byte value after a storage clear

    // ------------------------------------------------------------
    // Timekeeping
    // ------------------------------------------------------------
    localparam int          CRYSTAL_HZ       = 32768;      // Low-frequency source, in Hz
    localparam int          TICKS_PER_SECOND = CRYSTAL_HZ; // Source edges per second

    localparam logic [7:0]  SEC_MAX   = 8'h3B;          // 59
    localparam logic [7:0]  MIN_MAX   = 8'h3B;          // 59
    localparam logic [7:0]  HOUR_MAX  = 8'h17;          // 23
    localparam logic [7:0]  MONTH_MAX = 8'h0C;          // 12
    localparam logic [7:0]  DAY_FIRST = 8'h01;          // Days and months count from one
    localparam logic [7:0]  ZERO_VAL  = 8'h00;          // Seconds, minutes, hours start

    // Time of day, binary fields
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } tod_t;

    localparam tod_t TOD_RESET = '{month: 8'h01, day: 8'h01, hour: 8'h00,
                                   min: 8'h00, sec: 8'h00};

endpackage

// [include/ram_port_if.sv]
`timescale 1ns/10ps
// Write, read and clear path between the control logic and the byte array
interface ram_port_if;
    import rtc_pkg::*;
    logic              we;     // Write strobe, already cleared of locked bytes
    logic [ADDR_W-1:0] addr;   // Byte index
    logic [7:0]        wdata;  // Byte to store
    logic [7:0]        rdata;  // Byte at addr, combinational
    logic              clear;  // Level: wipe every byte
    modport ctrl  (output we, output addr, output wdata, output clear, input rdata);
    modport store (input we, input addr, input wdata, input clear, output rdata);
endinterface

// [core/rtc_ram.sv]
`timescale 1ns/10ps
module rtc_ram (
    input  wire logic    clock,
    ram_port_if.store    port
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem_reg [RAM_BYTES];   // Flip-flop array on the retention well

    // Read is combinational; the caller registers it
    assign port.rdata = mem_reg[port.addr];

    // Clear overrides writes, so a clear never leaves stale bytes
    always_ff @(posedge clock) begin
        if (port.clear) begin
            for (int i = 0; i < RAM_BYTES; i++) begin
                mem_reg[i] <= RAM_CLEAR; // R05
            end
        end else if (port.we) begin
            mem_reg[port.addr] <= port.wdata; // R01
        end
    end

endmodule

// [verif/rtc_chk.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for the clock and retained storage block
// ------------------------------------------------------------
module rtc_chk
    import rtc_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              retention_well_reset_n,
    input wire logic              secondary_well_reset_n,
    input wire logic              ram_req,
    input wire logic              ram_write,
    input wire logic [ADDR_W-1:0] ram_addr,
    input wire logic [7:0]        ram_rdata,
    input wire logic              ram_ack,
    input wire logic              ram_denied,
    input wire logic [1:0]        lock_set,
    input wire logic [1:0]        lock_state,
    input wire logic              time_load,
    input wire tod_t              time_value,
    input wire tod_t              time_now,
    input wire logic              second_tick,
    input wire logic              wake_event,
    input wire logic              wake_flag
);
    // Only the system reset masks checks; well resets are part of the rules
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Back-to-back requests are legal, so the second answer cycle follows the request
    property p_ack; ram_req |=> ram_ack ##1 (ram_ack == $past(ram_req)); endproperty
    a_ack: assert property (p_ack) else $error("answer not a single pulse");
    property p_den; ram_req && !ram_write && lock_state[0] && ram_addr[7:3] == 5'b0_0111
        |=> ram_denied && ram_rdata == 8'h00; endproperty
    a_den: assert property (p_den) else $error("locked read not refused");
    property p_den_ack; ram_denied |-> ram_ack; endproperty
    a_den_ack: assert property (p_den_ack) else $error("refusal without answer");
    property p_step; second_tick && !time_load |=> time_now != $past(time_now); endproperty
    a_step: assert property (p_step) else $error("time did not step");
    property p_load; time_load |=> time_now == $past(time_value); endproperty
    a_load: assert property (p_load) else $error("time load lost");
    property p_wake; wake_event |-> wake_flag ##1 !wake_event; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse wrong");
    property p_lock; (secondary_well_reset_n && retention_well_reset_n)[*4] ##0 lock_set[0]
        |=> lock_state[0]; endproperty
    a_lock: assert property (p_lock) else $error("lock not taken");
    property p_prim; !retention_well_reset_n [*3] |=> time_now == TOD_RESET
        && lock_state == 2'b00 && !wake_flag; endproperty
    a_prim: assert property (p_prim) else $error("primary reset incomplete");
    property p_sec; !secondary_well_reset_n [*3] |=> lock_state == 2'b00; endproperty
    a_sec: assert property (p_sec) else $error("locks survive reset");
endmodule

bind rtc_top rtc_chk u_rtc_chk (.clock(clock), .rst_n(rst_n),
    .retention_well_reset_n(retention_well_reset_n),
    .secondary_well_reset_n(secondary_well_reset_n), .ram_req(ram_req),
    .ram_write(ram_write), .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_ack(ram_ack),
    .ram_denied(ram_denied), .lock_set(lock_set), .lock_state(lock_state),
    .time_load(time_load), .time_value(time_value), .time_now(time_now),
    .second_tick(second_tick), .wake_event(wake_event), .wake_flag(wake_flag));

// [verif/rtc_top_tb.sv]
`timescale 1ns/10ps
module rtc_top_tb;
    import rtc_pkg::*;
    logic       clock, rst_n, retention_well_reset_n, secondary_well_reset_n, crystal_input;
    logic       ram_req, ram_write, ram_ack, ram_denied, time_load, second_tick;
    logic [7:0] ram_addr, ram_wdata, ram_rdata;
    logic [1:0] lock_set, lock_state;
    logic       alarm_load, alarm_enable, alarm_armed, wake_event, wake_flag, wake_clear;
    tod_t       time_value, time_now, alarm_value;
    int         bad_count, checks_done;                 // Mismatches and comparisons

    // Four source edges per second keeps the run short
    rtc_top #(.TICKS_PER_SECOND(4)) u_rtc_top (
        .clock                  (clock),
        .rst_n                  (rst_n),
        .retention_well_reset_n (retention_well_reset_n),
        .secondary_well_reset_n (secondary_well_reset_n),
        .crystal_input          (crystal_input),
        .ram_req                (ram_req),
        .ram_write              (ram_write),
        .ram_addr               (ram_addr),
        .ram_wdata              (ram_wdata),
        .ram_rdata              (ram_rdata),
        .ram_ack                (ram_ack),
        .ram_denied             (ram_denied),
        .lock_set               (lock_set),
        .lock_state             (lock_state),
        .time_load              (time_load),
        .time_value             (time_value),
        .time_now               (time_now),
        .second_tick            (second_tick),
        .alarm_load             (alarm_load),
        .alarm_enable           (alarm_enable),
        .alarm_value            (alarm_value),
        .alarm_armed            (alarm_armed),
        .wake_event             (wake_event),
        .wake_flag              (wake_flag),
        .wake_clear             (wake_clear)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One byte request; the answer is registered, so it is seen at the next fall
    task automatic ram_op(input logic w, input logic [7:0] a, d, exp_rd, input logic den);
        @(negedge clock);
        {ram_req, ram_write, ram_addr, ram_wdata} = {1'b1, w, a, d};
        @(negedge clock);
        ram_req = 1'b0;
        check(40'(ram_ack), 40'h1);
        check(40'(ram_denied), 40'(den));
        if (!w) check(40'(ram_rdata), 40'(exp_rd));
    endtask

    // Holds a well reset low long enough to be seen, then lets it settle
    task automatic pulse_low(ref logic pin);
        pin = 1'b0;
        repeat (4) @(negedge clock);
        pin = 1'b1;
        repeat (4) @(negedge clock);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_ram();
        ram_op(1, 8'h00, 8'h11, 8'h00, 0);
        ram_op(1, 8'hFF, 8'hEE, 8'h00, 0);
        ram_op(0, 8'h00, 8'h00, 8'h11, 0);
        ram_op(0, 8'hFF, 8'h00, 8'hEE, 0);
    endtask

    task automatic t_lock();
        ram_op(1, 8'h38, 8'h5A, 8'h00, 0);
        ram_op(1, 8'h37, 8'h3C, 8'h00, 0);
        ram_op(1, 8'hDF, 8'hC3, 8'h00, 0);
        @(negedge clock);
        lock_set = 2'b11;
        @(negedge clock);
        lock_set = 2'b00;
        check(40'(lock_state), 40'h3);
        ram_op(0, 8'h38, 8'h00, 8'h00, 1);
        ram_op(1, 8'h3F, 8'h77, 8'h00, 1);
        ram_op(0, 8'hDF, 8'h00, 8'h00, 1);
        ram_op(0, 8'hD8, 8'h00, 8'h00, 1);
        ram_op(0, 8'h37, 8'h00, 8'h3C, 0);
        pulse_low(secondary_well_reset_n);
        check(40'(lock_state), 40'h0);
        ram_op(0, 8'h38, 8'h00, 8'h5A, 0);
        ram_op(0, 8'h3F, 8'h00, 8'h00, 0);
    endtask

    // Month end rollover with an alarm on the new day
    task automatic t_time();
        int i;
        @(negedge clock);
        {time_load, time_value} = {1'b1, 40'h02_1C17_3B3B};
        {alarm_load, alarm_enable, alarm_value} = {2'b11, 40'h00_0100_0000};
        @(negedge clock);
        {time_load, alarm_load} = 2'b00;
        check(40'(alarm_armed), 40'h1);
        for (i = 0; i < 4; i++) begin
            crystal_input = 1'b0;
            repeat (3) @(negedge clock);
            crystal_input = 1'b1;
            if (i < 3) begin
                // A tick counted one rise too early would show exactly here
                repeat (3) @(negedge clock);
                check(40'(second_tick), 40'h0);
            end
        end
        for (i = 0; i < 12 && second_tick !== 1'b1; i++) @(negedge clock);
        if (i == 12) begin
            bad_count++;
            complete_run();
        end
        // The time steps one cycle after the tick
        check(time_now, 40'h02_1C17_3B3B);
        @(negedge clock);
        check(40'(second_tick), 40'h0);
        check(40'(wake_event), 40'h1);
        check(time_now, 40'h03_0100_0000);
        check(40'(wake_flag), 40'h1);
        wake_clear = 1'b1;
        @(negedge clock);
        wake_clear = 1'b0;
        check(40'(wake_flag), 40'h0);
        check(40'(wake_event), 40'h0);
    endtask

    task automatic t_primary();
        ram_op(1, 8'h10, 8'hA5, 8'h00, 0);
        @(negedge clock);
        lock_set = 2'b01;
        @(negedge clock);
        lock_set = 2'b00;
        // Primary reset stays high except for this deliberate storage clear
        pulse_low(retention_well_reset_n);
        check(time_now, TOD_RESET);
        check(40'({lock_state, alarm_armed, wake_flag}), 40'h0);
        ram_op(0, 8'h10, 8'h00, 8'h00, 0);
    endtask

    // ------------------------------------------------------------
    // Main sequence: all three resets together, then the scenarios
    // ------------------------------------------------------------
    initial begin
        {rst_n, retention_well_reset_n, secondary_well_reset_n, crystal_input} = 4'h0;
        {ram_req, ram_write, ram_addr, ram_wdata, lock_set} = '0;
        {time_load, time_value, alarm_load, alarm_enable, alarm_value, wake_clear} = '0;
        {bad_count, checks_done} = '0;
        repeat (6) @(negedge clock);
        // The system reset holds the well synchronisers idle, so the well
        // resets must outlast it to be seen and clear the retained state
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        // Both well resets rise after the system reset, each on its own net
        retention_well_reset_n = 1'b1;
        secondary_well_reset_n = 1'b1;
        repeat (4) @(negedge clock);
        t_ram();
        t_lock();
        t_time();
        t_primary();
        complete_run();
    end
endmodule
